// >>> pkg/jps_di_if.sv
`timescale 1ns/1ps
`default_nettype none
// Decoded digital input functions passed from the decoder to the top.
interface jps_di_if;
    logic servo_enable_input;
    logic torque_limit_enable;
    logic speed_select_bit0;
    logic speed_select_bit1;
    logic alarm_clear_input;
    logic emergency_stop_input;
    logic estop_assigned;
    logic reverse_limit_input;
    logic rev_assigned;
    logic forward_limit_input;
    logic fwd_assigned;

    modport src (
        output servo_enable_input, torque_limit_enable,
        output speed_select_bit0, speed_select_bit1, alarm_clear_input,
        output emergency_stop_input, estop_assigned,
        output reverse_limit_input, rev_assigned,
        output forward_limit_input, fwd_assigned
    );
    modport dst (
        input servo_enable_input, torque_limit_enable,
        input speed_select_bit0, speed_select_bit1, alarm_clear_input,
        input emergency_stop_input, estop_assigned,
        input reverse_limit_input, rev_assigned,
        input forward_limit_input, fwd_assigned
    );
endinterface
`default_nettype wire

// >>> pkg/jps_pkg.sv
// Shared constants and types of the jog and preset speed selector.
package jps_pkg;

    // Widths of the digital inputs, function codes and speed words.
    localparam int unsigned DI_COUNT = 6;
    localparam int unsigned CODE_W = 8;
    localparam int unsigned MODE_W = 8;
    localparam int unsigned SPEED_W = 16;
    localparam int unsigned DIGIT_COUNT = 4;
    localparam int unsigned DIGIT_W = 2;

    // Input function codes; zero leaves an input without any function.
    localparam logic [7:0] FN_DISABLED = 8'h00;
    localparam logic [7:0] FN_EMERGENCY_STOP = 8'h15;
    localparam logic [7:0] FN_REVERSE_LIMIT = 8'h16;
    localparam logic [7:0] FN_FORWARD_LIMIT = 8'h17;
    localparam logic [7:0] FN_SERVO_ENABLE = 8'h65;
    localparam logic [7:0] FN_ALARM_CLEAR = 8'h66;
    localparam logic [7:0] FN_TORQUE_LIMIT = 8'h6D;
    localparam logic [7:0] FN_SPEED_SEL0 = 8'h72;
    localparam logic [7:0] FN_SPEED_SEL1 = 8'h73;

    // Factory functions of inputs four to six.
    localparam logic [7:0] INPUT4_DEFAULT_CODE = FN_REVERSE_LIMIT;
    localparam logic [7:0] INPUT5_DEFAULT_CODE = FN_FORWARD_LIMIT;
    localparam logic [7:0] INPUT6_DEFAULT_CODE = FN_EMERGENCY_STOP;

    // Operating mode value that selects speed control.
    localparam logic [7:0] MODE_SPEED_CONTROL = 8'h04;
    localparam logic [7:0] MODE_RESET_VALUE = 8'h00;

    // Speed figures in rpm.
    localparam logic signed [15:0] PRESET_LIMIT_RPM = 16'sh1388;
    localparam logic [15:0] JOG_DEFAULT_RPM = 16'h0014;
    localparam logic [15:0] JOG_MAX_RPM = 16'h1388;

    // Operating states of the command selector.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_JOG_EDIT = 2'b01,
        ST_JOG_RUN = 2'b10
    } jps_state_type;

endpackage

// >>> tb/jps_jog_and_preset_speed_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench of the selector; the panel model drives keys and contacts.
module jps_jog_and_preset_speed_select_tb;
    // Counts a comparison and reports a mismatch at once.
    `define JPS_CHK(nm, ex, got) \
        begin \
            tests_run++; \
            if ((got) !== (ex)) begin \
                err_total++; \
                $display("wrong value %s expected %0d seen %0d", nm, ex, got); \
            end \
        end
    // One ordinary speed mode case.
    typedef struct {
        logic [5:0] di;
        logic en;
        logic signed [15:0] spd;
    } jps_row_type;
    // Bench requests, panel signals and selector outputs.
    logic clk_i, srst_i, servo_en, jog_mode, jog_run, estop, rev, spd_mode;
    logic [5:0] key_req, di_req, key, di;
    logic [7:0] mode_req, mode, act_mode;
    logic [7:0] code [6];
    logic signed [15:0] spd;
    logic [15:0] edit_val, jog_spd;
    logic [1:0] edit_dig;
    int err_total = 0, tests_run = 0;
    logic fwd, torq;
    jps_row_type rows [5];

    jps_panel_model jps_panel_model_i (.clk_i(clk_i),
        .servo_enable_i(servo_en), .key_req_i(key_req),
        .contact_req_i(di_req), .mode_req_i(mode_req), .key_o(key),
        .contact_o(di), .mode_o(mode));
    jps_jog_and_preset_speed_select jps_jog_and_preset_speed_select_i (
        .clk_i(clk_i), .srst_i(srst_i), .jog_key_i(key[0]),
        .mode_key_i(key[1]), .up_key_i(key[2]), .down_key_i(key[3]),
        .shift_key_i(key[4]), .set_key_i(key[5]), .digital_input_i(di),
        .input1_function_code_i(code[0]), .input2_function_code_i(code[1]),
        .input3_function_code_i(code[2]), .input4_function_code_i(code[3]),
        .input5_function_code_i(code[4]), .input6_function_code_i(code[5]),
        .operating_mode_setting_i(mode), .speed_preset_one_i(16'sh0BB8),
        .speed_preset_two_i(16'sh0064), .speed_preset_three_i(16'shE890),
        .servo_enable_o(servo_en), .torque_limit_enable_o(torq),
        .speed_cmd_o(spd), .jog_mode_o(jog_mode), .jog_run_o(jog_run),
        .jog_edit_value_o(edit_val), .jog_edit_digit_o(edit_dig),
        .jog_speed_o(jog_spd), .emergency_stop_alarm_o(estop),
        .reverse_limit_alarm_o(rev), .forward_limit_alarm_o(fwd),
        .active_mode_o(act_mode), .speed_control_mode_o(spd_mode));

    // Waits whole cycles, then settles on the falling edge.
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Holds reset for two cycles, as a power restart.
    task automatic restart();
        @(posedge clk_i) srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        wt(4);
    endtask
    task automatic set_di(input logic [5:0] v);
        @(posedge clk_i) di_req <= v;
        wt(8);
    endtask
    task automatic press(input int k);
        @(posedge clk_i) key_req[k] <= 1'b1;
        wt(4);
        @(posedge clk_i) key_req[k] <= 1'b0;
        wt(6);
    endtask
    // Holds a jog key, then releases it and expects a stop.
    task automatic hold(input int k, input logic signed [15:0] ex);
        @(posedge clk_i) key_req[k] <= 1'b1;
        wt(8);
        `JPS_CHK("jog speed", ex, spd)
        @(posedge clk_i) key_req[k] <= 1'b0;
        wt(8);
        `JPS_CHK("jog stop", 16'sh0000, spd)
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Clock of 20 ns period.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Cuts the run short far beyond the expected few hundred cycles.
    initial begin
        repeat (3000) @(posedge clk_i);
        err_total++;
        end_sim();
    end
    // Speed mode rows first, then alarms, restart, jog and stop cases.
    initial begin
        srst_i = 1'b1;
        key_req = '0;
        di_req = '0;
        mode_req = jps_pkg::MODE_SPEED_CONTROL;
        code = '{jps_pkg::FN_SERVO_ENABLE, jps_pkg::FN_TORQUE_LIMIT,
            jps_pkg::FN_SPEED_SEL0, jps_pkg::FN_SPEED_SEL1,
            jps_pkg::FN_ALARM_CLEAR, jps_pkg::FN_DISABLED};
        rows = '{'{6'h01, 1'b1, 16'sh0000}, '{6'h05, 1'b1, 16'sh0BB8},
            '{6'h09, 1'b1, 16'sh0064}, '{6'h0D, 1'b1, 16'shEC78},
            '{6'h0C, 1'b0, 16'sh0000}};
        restart();
        `JPS_CHK("active mode", 8'h04, act_mode)
        `JPS_CHK("estop alarm", 1'b0, estop)
        foreach (rows[i]) begin
            set_di(rows[i].di);
            `JPS_CHK("speed command", rows[i].spd, spd)
            `JPS_CHK("servo enable", rows[i].en, servo_en)
        end
        $display("test speed rows done");
        set_di(6'h07);
        `JPS_CHK("torque limit", 1'b1, torq)
        @(posedge clk_i) code[3] <= jps_pkg::FN_REVERSE_LIMIT;
        wt(6);
        `JPS_CHK("reverse alarm", 1'b1, rev)
        `JPS_CHK("speed under alarm", 16'sh0000, spd)
        set_di(6'h1D);
        `JPS_CHK("cleared alarm", 1'b0, rev)
        set_di(6'h08);
        `JPS_CHK("servo off", 1'b0, servo_en)
        @(posedge clk_i) mode_req <= 8'h00;
        wt(4);
        `JPS_CHK("mode before restart", 8'h04, act_mode)
        restart();
        `JPS_CHK("mode after restart", 8'h00, act_mode)
        `JPS_CHK("no alarm from reset", 1'b0, rev)
        `JPS_CHK("speed mode flag", 1'b0, spd_mode)
        $display("test alarm and restart done");
        press(0);
        `JPS_CHK("jog mode", 1'b1, jog_mode)
        `JPS_CHK("jog servo", 1'b1, servo_en)
        press(2);
        `JPS_CHK("edit value", 16'h0015, edit_val)
        press(4);
        `JPS_CHK("edit digit", 2'h1, edit_dig)
        press(2);
        `JPS_CHK("edit value", 16'h001F, edit_val)
        press(5);
        `JPS_CHK("jog speed", 16'h001F, jog_spd)
        `JPS_CHK("jog run", 1'b1, jog_run)
        set_di(6'h00);
        `JPS_CHK("limit in jog", 1'b1, rev)
        hold(2, 16'sh001F);
        hold(3, -16'sh001F);
        press(1);
        `JPS_CHK("jog left", 1'b0, jog_mode)
        $display("test jog done");
        @(posedge clk_i) code[5] <= jps_pkg::FN_EMERGENCY_STOP;
        code[4] <= jps_pkg::INPUT5_DEFAULT_CODE;
        wt(6);
        `JPS_CHK("estop alarm", 1'b1, estop)
        `JPS_CHK("forward alarm", 1'b1, fwd)
        press(0);
        `JPS_CHK("jog refused", 1'b0, jog_mode)
        $display("test emergency stop done");
        end_sim();
    end
endmodule // jps_jog_and_preset_speed_select_tb
`default_nettype wire

// >>> tb/jps_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// Operator panel keys, input contacts and mode entry of the drive.
module jps_panel_model (
    // Clock and servo state from the drive.
    input wire logic clk_i,
    input wire logic servo_enable_i,
    // Requests from the bench.
    input wire logic [5:0] key_req_i,
    input wire logic [5:0] contact_req_i,
    input wire logic [7:0] mode_req_i,
    // Keys, contacts and mode setting towards the drive.
    output logic [5:0] key_o,
    output logic [5:0] contact_o,
    output logic [7:0] mode_o
);
    // Keys and contacts follow requests; mode is written only servo off.
    always @(posedge clk_i) begin
        key_o <= key_req_i;
        contact_o <= contact_req_i;
        if (servo_enable_i !== 1'b1) begin
            mode_o <= mode_req_i;
        end
    end
endmodule // jps_panel_model
`default_nettype wire

// >>> tb/jps_props.sv
`timescale 1ns/1ps
`default_nettype none
// Concurrent checks of the selector, seen from its ports.
module jps_props #(
    parameter int unsigned W = jps_pkg::SPEED_W
) (
    // Clock, reset and jog keys.
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic up_key_i,
    input wire logic down_key_i,
    // Watched outputs.
    input wire logic servo_enable_o,
    input wire logic signed [W-1:0] speed_cmd_o,
    input wire logic jog_mode_o,
    input wire logic jog_run_o,
    input wire logic [W-1:0] jog_speed_o,
    input wire logic emergency_stop_alarm_o,
    input wire logic reverse_limit_alarm_o,
    input wire logic forward_limit_alarm_o,
    input wire logic [7:0] active_mode_o,
    input wire logic speed_control_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // Steps of a held or released jog key.
    sequence up_held;
        jog_run_o && up_key_i && !down_key_i;
    endsequence
    sequence down_held;
        jog_run_o && down_key_i && !up_key_i;
    endsequence
    sequence keys_off;
        jog_mode_o && !up_key_i && !down_key_i;
    endsequence

    // Jog motion always has the output stage enabled.
    AST_JOG_ENABLED: assert property (jog_mode_o |-> servo_enable_o)
        else $error("jog mode without servo enable");
    // Held keys turn the motor at the committed jog speed.
    AST_JOG_CCW: assert property (up_held [*4] ##1 jog_run_o
        |-> speed_cmd_o == $signed(jog_speed_o))
        else $error("jog ccw speed wrong");
    AST_JOG_CW: assert property (down_held [*4] ##1 jog_run_o
        |-> speed_cmd_o == -$signed(jog_speed_o))
        else $error("jog cw speed wrong");
    AST_JOG_STOP: assert property (keys_off [*4] ##1 jog_mode_o
        |-> speed_cmd_o == '0)
        else $error("motor not stopped after key release");
    // Outside jog and speed mode the command stays at zero.
    AST_NO_SPEED_MODE: assert property (!jog_mode_o &&
        !$past(jog_mode_o) && !$past(jog_mode_o, 2) &&
        !speed_control_mode_o |-> speed_cmd_o == '0)
        else $error("speed command outside speed mode");
    // A standing emergency stop alarm keeps jog out.
    AST_ESTOP_NO_JOG: assert property (emergency_stop_alarm_o &&
        $past(emergency_stop_alarm_o) |-> !jog_mode_o)
        else $error("jog active under emergency stop");
    AST_SPEED_RANGE: assert property (
        speed_cmd_o <= jps_pkg::PRESET_LIMIT_RPM &&
        speed_cmd_o >= -jps_pkg::PRESET_LIMIT_RPM)
        else $error("speed command beyond limit");
    AST_MODE_FLAG: assert property (speed_control_mode_o ==
        (active_mode_o == jps_pkg::MODE_SPEED_CONTROL))
        else $error("speed mode flag disagrees with mode");
    // The active mode only changes across a restart.
    AST_MODE_HELD: assert property (!$past(srst_i) &&
        !$past(srst_i, 2) && !$past(srst_i, 3) |-> $stable(active_mode_o))
        else $error("active mode changed without restart");
    AST_RESTART_CLEARS: assert property (disable iff (1'b0)
        srst_i |=> !emergency_stop_alarm_o && !reverse_limit_alarm_o &&
        !forward_limit_alarm_o)
        else $error("alarm survived restart");
endmodule // jps_props
bind jps_jog_and_preset_speed_select jps_props #(.W(W)) jps_props_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .up_key_i(up_key_i),
    .down_key_i(down_key_i),
    .servo_enable_o(servo_enable_o),
    .speed_cmd_o(speed_cmd_o),
    .jog_mode_o(jog_mode_o),
    .jog_run_o(jog_run_o),
    .jog_speed_o(jog_speed_o),
    .emergency_stop_alarm_o(emergency_stop_alarm_o),
    .reverse_limit_alarm_o(reverse_limit_alarm_o),
    .forward_limit_alarm_o(forward_limit_alarm_o),
    .active_mode_o(active_mode_o),
    .speed_control_mode_o(speed_control_mode_o)
);
`default_nettype wire

// >>> verilog/jps_di_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Maps each synchronised input level onto the function its code assigns.
module jps_di_decode #(
    parameter int unsigned N = jps_pkg::DI_COUNT
) (
    // Synchronised input levels, one means ON.
    input wire logic [N-1:0] level_i,
    // Function code of each input.
    input wire logic [N-1:0][7:0] code_i,
    // Decoded functions.
    jps_di_if.src di
);

    // Per-input comparison with one function code.
    function automatic logic [N-1:0] hits(
        input logic [N-1:0][7:0] codes,
        input logic [7:0] fn
    );
        logic [N-1:0] h;
        h = '0;
        for (int i = 0; i < N; i++) begin
            h[i] = (codes[i] == fn);
        end
        return h;
    endfunction

    // Which inputs carry each function.
    wire [N-1:0] son_m = hits(code_i, jps_pkg::FN_SERVO_ENABLE);
    wire [N-1:0] trq_m = hits(code_i, jps_pkg::FN_TORQUE_LIMIT);
    wire [N-1:0] s0_m = hits(code_i, jps_pkg::FN_SPEED_SEL0);
    wire [N-1:0] s1_m = hits(code_i, jps_pkg::FN_SPEED_SEL1);
    wire [N-1:0] clr_m = hits(code_i, jps_pkg::FN_ALARM_CLEAR);
    wire [N-1:0] est_m = hits(code_i, jps_pkg::FN_EMERGENCY_STOP);
    wire [N-1:0] rev_m = hits(code_i, jps_pkg::FN_REVERSE_LIMIT);
    wire [N-1:0] fwd_m = hits(code_i, jps_pkg::FN_FORWARD_LIMIT);

    // A code of zero matches no function, so the input has none.
    assign di.servo_enable_input = |(son_m & level_i);
    assign di.torque_limit_enable = |(trq_m & level_i);
    assign di.speed_select_bit0 = |(s0_m & level_i);
    assign di.speed_select_bit1 = |(s1_m & level_i);
    assign di.alarm_clear_input = |(clr_m & level_i);
    assign di.emergency_stop_input = |(est_m & level_i);
    assign di.estop_assigned = |est_m;
    assign di.reverse_limit_input = |(rev_m & level_i);
    assign di.rev_assigned = |rev_m;
    assign di.forward_limit_input = |(fwd_m & level_i);
    assign di.fwd_assigned = |fwd_m;

endmodule // jps_di_decode
`default_nettype wire

// >>> verilog/jps_jog_and_preset_speed_select.sv
`timescale 1ns/1ps
`default_nettype none
module jps_jog_and_preset_speed_select #(
    parameter int unsigned N = jps_pkg::DI_COUNT,
    parameter int unsigned W = jps_pkg::SPEED_W
) (
    // Clock and synchronous reset; reset stands for a power restart.
    input wire logic clk_i,
    input wire logic srst_i,
    // Keypad keys, high while pressed.
    input wire logic jog_key_i,
    input wire logic mode_key_i,
    input wire logic up_key_i,
    input wire logic down_key_i,
    input wire logic shift_key_i,
    input wire logic set_key_i,
    // Digital input pins, bit zero is input one.
    input wire logic [N-1:0] digital_input_i,
    // Function codes of the six inputs.
    input wire logic [7:0] input1_function_code_i,
    input wire logic [7:0] input2_function_code_i,
    input wire logic [7:0] input3_function_code_i,
    input wire logic [7:0] input4_function_code_i,
    input wire logic [7:0] input5_function_code_i,
    input wire logic [7:0] input6_function_code_i,
    // Operating mode setting and speed presets in rpm.
    input wire logic [7:0] operating_mode_setting_i,
    input wire logic signed [W-1:0] speed_preset_one_i,
    input wire logic signed [W-1:0] speed_preset_two_i,
    input wire logic signed [W-1:0] speed_preset_three_i,
    // Drive controls towards the speed loop.
    output logic servo_enable_o,
    output logic torque_limit_enable_o,
    output logic signed [W-1:0] speed_cmd_o,
    // Jog status.
    output logic jog_mode_o,
    output logic jog_run_o,
    output logic [W-1:0] jog_edit_value_o,
    output logic [1:0] jog_edit_digit_o,
    output logic [W-1:0] jog_speed_o,
    // Alarms and mode status.
    output logic emergency_stop_alarm_o,
    output logic reverse_limit_alarm_o,
    output logic forward_limit_alarm_o,
    output logic [7:0] active_mode_o,
    output logic speed_control_mode_o
);

    localparam int unsigned PW = N + 6;

    // Clamp of a preset to the allowed speed range.
    function automatic logic signed [W-1:0] clamp(
        input logic signed [W-1:0] v
    );
        if (v > jps_pkg::PRESET_LIMIT_RPM) begin
            clamp = jps_pkg::PRESET_LIMIT_RPM;
        end else if (v < -jps_pkg::PRESET_LIMIT_RPM) begin
            clamp = -jps_pkg::PRESET_LIMIT_RPM;
        end else begin
            clamp = v;
        end
    endfunction

    // Pins gathered for the two-stage synchroniser.
    wire [PW-1:0] pins_raw = {set_key_i, shift_key_i, down_key_i,
                              up_key_i, mode_key_i, jog_key_i,
                              digital_input_i};
    logic [PW-1:0] sync1_q;
    logic [PW-1:0] sync2_q;
    logic [PW-1:0] prev_q;
    logic [1:0] warm_q;

    // Two flip-flops before use, and a third stage for edge detection.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            warm_q <= 2'h0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            warm_q <= {warm_q[0], 1'b1}; // Fills as sync2_q does.
        end
    end

    // Synchronised levels and press edges; a level of one is ON.
    wire [PW-1:0] press = sync2_q & ~prev_q;
    wire [N-1:0] di_level = sync2_q[N-1:0];
    wire jog_press = press[N];
    wire mode_press = press[N+1];
    wire up_press = press[N+2];
    wire down_press = press[N+3];
    wire shift_press = press[N+4];
    wire set_press = press[N+5];
    wire up_held = sync2_q[N+2];
    wire down_held = sync2_q[N+3];

    // Function decoding of the digital inputs.
    jps_di_if di_bus ();
    wire [N-1:0][7:0] codes = {input6_function_code_i,
                               input5_function_code_i,
                               input4_function_code_i,
                               input3_function_code_i,
                               input2_function_code_i,
                               input1_function_code_i};

    jps_di_decode #(
        .N(N)
    ) u_decode (
        .level_i(di_level),
        .code_i(codes),
        .di(di_bus.src)
    );

    // Operating mode capture after a restart.
    logic mode_load_q;
    logic [7:0] active_mode_q;

    // The setting is sampled once after reset release, never later.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_load_q <= 1'b1;
            active_mode_q <= jps_pkg::MODE_RESET_VALUE;
        end else begin
            mode_load_q <= 1'b0;
            if (mode_load_q) begin
                active_mode_q <= operating_mode_setting_i;
            end
        end
    end

    wire speed_mode = (active_mode_q == jps_pkg::MODE_SPEED_CONTROL);

    // Assigned input reads OFF; reset zeros in sync2_q are not pin levels.
    wire est_set = warm_q[1] & di_bus.estop_assigned &
                   ~di_bus.emergency_stop_input;
    wire rev_set = warm_q[1] & di_bus.rev_assigned &
                   ~di_bus.reverse_limit_input;
    wire fwd_set = warm_q[1] & di_bus.fwd_assigned &
                   ~di_bus.forward_limit_input;
    wire alarm_clr = di_bus.alarm_clear_input;

    // Sticky alarms; a new event wins over a clear in the same cycle.
    wire est_d = est_set | (emergency_stop_alarm_o & ~alarm_clr);
    wire rev_d = rev_set | (reverse_limit_alarm_o & ~alarm_clr);
    wire fwd_d = fwd_set | (forward_limit_alarm_o & ~alarm_clr);

    // Alarm registers; reset (restart) clears them all.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            emergency_stop_alarm_o <= 1'b0;
            reverse_limit_alarm_o <= 1'b0;
            forward_limit_alarm_o <= 1'b0;
        end else begin
            emergency_stop_alarm_o <= est_d;
            reverse_limit_alarm_o <= rev_d;
            forward_limit_alarm_o <= fwd_d;
        end
    end

    // Jog state machine.
    jps_pkg::jps_state_type state_q;
    jps_pkg::jps_state_type state_d;

    // Limit alarms are deliberately absent from these conditions.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            jps_pkg::ST_IDLE: begin
                if (jog_press && !emergency_stop_alarm_o) begin
                    state_d = jps_pkg::ST_JOG_EDIT;
                end
            end
            jps_pkg::ST_JOG_EDIT: begin
                if (emergency_stop_alarm_o) begin
                    state_d = jps_pkg::ST_IDLE;
                end else if (mode_press) begin
                    state_d = jps_pkg::ST_IDLE;
                end else if (set_press) begin
                    state_d = jps_pkg::ST_JOG_RUN;
                end
            end
            jps_pkg::ST_JOG_RUN: begin
                if (emergency_stop_alarm_o) begin
                    state_d = jps_pkg::ST_IDLE;
                end else if (mode_press) begin
                    state_d = jps_pkg::ST_IDLE;
                end else if (shift_press) begin
                    state_d = jps_pkg::ST_JOG_EDIT;
                end
            end
            default: begin
                state_d = jps_pkg::ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= jps_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Decoded states.
    wire in_edit = (state_q == jps_pkg::ST_JOG_EDIT);
    wire in_run = (state_q == jps_pkg::ST_JOG_RUN);
    wire in_jog = in_edit | in_run;

    // Jog speed editor; keys edit only while the value is shown.
    jps_jog_edit #(
        .W(W)
    ) u_edit (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .up_i(up_press & in_edit),
        .down_i(down_press & in_edit),
        .shift_i(shift_press & in_edit),
        .set_i(set_press & in_edit),
        .edit_value_o(jog_edit_value_o),
        .digit_o(jog_edit_digit_o),
        .jog_speed_o(jog_speed_o)
    );

    // Jog command: one key held gives motion, none or both stop.
    wire signed [W-1:0] jog_pos = $signed(jog_speed_o);
    wire signed [W-1:0] jog_neg = -$signed(jog_speed_o);
    wire run_ccw = in_run & up_held & ~down_held;
    wire run_cw = in_run & down_held & ~up_held;
    wire signed [W-1:0] jog_cmd = run_ccw ? jog_pos :
                                  run_cw ? jog_neg :
                                  '0;

    // Preset selection from the two select bits, high then low.
    wire [1:0] sel = {di_bus.speed_select_bit1, di_bus.speed_select_bit0};
    wire signed [W-1:0] preset_one = clamp(speed_preset_one_i);
    wire signed [W-1:0] preset_two = clamp(speed_preset_two_i);
    wire signed [W-1:0] preset_three = clamp(speed_preset_three_i);
    wire signed [W-1:0] preset_cmd = (sel == 2'h1) ? preset_one :
                                     (sel == 2'h2) ? preset_two :
                                     (sel == 2'h3) ? preset_three :
                                     '0;

    // Speed command needs speed mode, the enable input and no alarm; servo enable needs the same but ignores the limit alarms.
    wire any_alarm = emergency_stop_alarm_o | reverse_limit_alarm_o |
                     forward_limit_alarm_o;
    wire speed_run = speed_mode & ~in_jog &
                     di_bus.servo_enable_input & ~any_alarm;
    wire speed_enable = speed_mode & ~in_jog &
                        di_bus.servo_enable_input &
                        ~emergency_stop_alarm_o;

    // Positive command turns CCW, negative CW, applied at once.
    wire signed [W-1:0] cmd_d = in_jog ? jog_cmd :
                                speed_run ? preset_cmd :
                                '0;

    // Registered drive outputs.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            servo_enable_o <= 1'b0;
            torque_limit_enable_o <= 1'b0;
            speed_cmd_o <= '0;
            jog_mode_o <= 1'b0;
            jog_run_o <= 1'b0;
        end else begin
            servo_enable_o <= (state_d != jps_pkg::ST_IDLE) |
                              speed_enable;
            torque_limit_enable_o <= speed_enable &
                                     di_bus.torque_limit_enable;
            speed_cmd_o <= cmd_d;
            jog_mode_o <= (state_d != jps_pkg::ST_IDLE);
            jog_run_o <= (state_d == jps_pkg::ST_JOG_RUN);
        end
    end

    // Registered mode status.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            active_mode_o <= jps_pkg::MODE_RESET_VALUE;
            speed_control_mode_o <= 1'b0;
        end else begin
            active_mode_o <= active_mode_q;
            speed_control_mode_o <= speed_mode;
        end
    end

endmodule // jps_jog_and_preset_speed_select
`default_nettype wire

// >>> verilog/jps_jog_edit.sv
`timescale 1ns/1ps
`default_nettype none
// Digit-wise editor of the jog speed with a separate committed value.
module jps_jog_edit #(
    parameter int unsigned W = jps_pkg::SPEED_W,
    parameter logic [15:0] MAX_RPM = jps_pkg::JOG_MAX_RPM
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // One-cycle key pulses, valid only while editing.
    input wire logic up_i,
    input wire logic down_i,
    input wire logic shift_i,
    input wire logic set_i,
    // Edited value, digit under edit and committed jog speed.
    output logic [W-1:0] edit_value_o,
    output logic [1:0] digit_o,
    output logic [W-1:0] jog_speed_o
);

    // Weight of the decimal digit under edit.
    function automatic logic [W-1:0] step_of(input logic [1:0] pos);
        case (pos)
            2'h0: step_of = W'(1);
            2'h1: step_of = W'(10);
            2'h2: step_of = W'(100);
            default: step_of = W'(1000);
        endcase
    endfunction

    // Saturating increment and decrement of the edited value.
    wire [W-1:0] step = step_of(digit_o);
    wire [W-1:0] room = W'(MAX_RPM) - edit_value_o;
    wire [W-1:0] inc_v = (room < step) ? W'(MAX_RPM) : edit_value_o + step;
    wire [W-1:0] dec_v = (edit_value_o < step) ? '0 : edit_value_o - step;

    // Edit, digit shift and commit.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            edit_value_o <= jps_pkg::JOG_DEFAULT_RPM;
            digit_o <= 2'h0;
            jog_speed_o <= jps_pkg::JOG_DEFAULT_RPM;
        end else begin
            if (up_i) begin
                edit_value_o <= inc_v;
            end else if (down_i) begin
                edit_value_o <= dec_v;
            end
            if (shift_i) begin
                digit_o <= digit_o + 2'h1;
            end
            if (set_i) begin
                jog_speed_o <= edit_value_o;
            end
        end
    end

endmodule // jps_jog_edit
`default_nettype wire
